// *** rtl/ic_status_pkg.sv ***
// Purpose: Constants for the input change and interrupt status block
// Assumes: Registers reached over the device's parallel register port
// Notes: Register addresses are register-port addresses, 4 bits wide
package ic_status_pkg;
  localparam logic [3:0] ADDR_AUX_CTRL = 4'h4;
  localparam logic [3:0] ADDR_INPUT_CHANGE = 4'h4;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h5;
  localparam logic [3:0] ADDR_INT_MASK = 4'h5;
  localparam logic [7:0] AUX_CTRL_RESET = 8'h00;
  localparam logic [7:0] INT_MASK_RESET = 8'h00;
  localparam logic [7:0] INT_STATUS_RESET = 8'h00;
  localparam int CT_MODE_LSB = 4;
  localparam int CT_MODE_MSB = 6;
  localparam int CHANGE_BIT = 7;
  localparam int DIV16_LAST = 15;
  typedef enum logic [2:0] {
    CT_CNT_PIN2 = 3'h0,
    CT_CNT_CHA_TX = 3'h1,
    CT_CNT_CHB_TX = 3'h2,
    CT_CNT_XTAL16 = 3'h3,
    CT_TMR_PIN2 = 3'h4,
    CT_TMR_PIN2_16 = 3'h5,
    CT_TMR_XTAL = 3'h6,
    CT_TMR_XTAL16 = 3'h7
  } ct_source_e;
endpackage : ic_status_pkg

// *** rtl/input_change_interrupt_status.sv ***
// Purpose: Input change register, interrupt status/mask and counter/timer source select
// Assumes: Reads are one-cycle strobes; inputs synchronous to clk_in except general pins and counter/timer source clocks
// Notes: Counter/timer datapath lives elsewhere; it gets a tick and a mode flag
// Functional notes
// - Counter mode codes 000-011 clock the counter from pin 2, channel A tx, channel B tx, crystal/16.
// - Timer mode codes 100-111 clock from pin 2, pin 2/16, crystal, crystal/16.
// - Timer mode codes make the counter/timer produce a square wave, not a one-shot count.
// - Upper four change bits set on a change of state at inputs 3 down to 0.
// - Reading the input change register clears all four change bits.
// - Reading the input change register also clears the summary status bit.
// - Lower four bits of the input change register return the live input levels.
// - The active-low interrupt output is low when any status bit and its mask bit are both 1.
// - A status bit with mask 0 does not affect the interrupt output.
// - Status reads return unmasked status regardless of the mask.
// - Reset clears the four change bits and the summary bit; status bits 6 to 0 follow other_status_in.
// - The summary bit sets on a change at an input whose enable bit is set.
// - The summary bit is bit 7 of the interrupt status register.
// - Each low auxiliary control bit gates its input's change event, not the stored change flag, into the summary bit.
// - Counter/timer mode and source sit in auxiliary control bits 6 to 4.
`timescale 1ns/1ps
`default_nettype none
module input_change_interrupt_status
  import ic_status_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  input wire logic general_input_0,
  input wire logic general_input_1,
  input wire logic general_input_2,
  input wire logic general_input_3,
  input wire logic chan_a_tx_bit_clock,
  input wire logic chan_b_tx_bit_clock,
  input wire logic crystal_clock_in,
  input wire logic [6:0] other_status_in,
  output logic ct_tick_out,
  output logic ct_square_mode_out,
  output logic irq_out_low
);
  logic [7:0] auxiliary_control_reg;
  logic [7:0] interrupt_mask_reg;
  logic [3:0] change_flags;
  logic change_summary;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] prev;
  logic [3:0] pin_raw;
  logic [3:0] change_evt;
  logic [2:0] src_raw;
  logic [2:0] src_s1;
  logic [2:0] src_s2;
  logic [2:0] src_prev;
  logic [2:0] src_rise;
  logic [3:0] div_pin2;
  logic [3:0] div_xtal;
  logic [7:0] interrupt_status_reg;
  logic [7:0] next_rdata;
  logic [2:0] ct_mode;
  logic next_tick;
  logic rd_change;
  logic rd_status;
  logic wr_aux;
  logic wr_mask;
  logic summary_evt;
  logic pin2_div_evt;
  logic xtal_div_evt;
  logic ct_timer;
  logic [2:0] sync_fill;
  logic sync_ready;
  logic pin2_rise;

  assign pin_raw = {general_input_3, general_input_2, general_input_1, general_input_0};
  assign src_raw = {crystal_clock_in, chan_b_tx_bit_clock, chan_a_tx_bit_clock};
  assign rd_change = rd_in && (addr_in == ADDR_INPUT_CHANGE);
  assign rd_status = rd_in && (addr_in == ADDR_INT_STATUS);
  assign wr_aux = wr_in && (addr_in == ADDR_AUX_CTRL);
  assign wr_mask = wr_in && (addr_in == ADDR_INT_MASK);

  // sync and compare
  // No edges until the synchroniser holds real samples
  assign sync_ready = sync_fill[2];
  assign change_evt = (sync2 ^ prev) & {4{sync_ready}};
  assign pin2_rise = change_evt[2] && sync2[2];
  assign summary_evt = |(change_evt & auxiliary_control_reg[3:0]);

  assign ct_mode = auxiliary_control_reg[CT_MODE_MSB:CT_MODE_LSB];
  assign ct_timer = ct_mode[2];
  assign pin2_div_evt = pin2_rise && (div_pin2 == 4'(DIV16_LAST));
  assign xtal_div_evt = src_rise[2] && (div_xtal == 4'(DIV16_LAST));
  assign src_rise = src_s2 & ~src_prev & {3{sync_ready}};

  always_comb begin
    unique case (ct_source_e'(ct_mode))
      CT_CNT_PIN2: next_tick = pin2_rise;
      CT_CNT_CHA_TX: next_tick = src_rise[0];
      CT_CNT_CHB_TX: next_tick = src_rise[1];
      CT_CNT_XTAL16: next_tick = xtal_div_evt;
      CT_TMR_PIN2: next_tick = pin2_rise;
      CT_TMR_PIN2_16: next_tick = pin2_div_evt;
      CT_TMR_XTAL: next_tick = src_rise[2];
      CT_TMR_XTAL16: next_tick = xtal_div_evt;
    endcase
  end

  assign interrupt_status_reg = {change_summary, other_status_in};

  always_comb begin
    next_rdata = 8'h00;
    if (rd_change) begin
      next_rdata = {change_flags, sync2};
    end else if (rd_status) begin
      next_rdata = interrupt_status_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      prev <= 4'h0;
      src_s1 <= 3'h0;
      src_s2 <= 3'h0;
      src_prev <= 3'h0;
      sync_fill <= 3'h0;
    end else begin
      sync_fill <= {sync_fill[1:0], 1'b1};
      sync1 <= pin_raw;
      sync2 <= sync1;
      prev <= sync2;
      src_s1 <= src_raw;
      src_s2 <= src_s1;
      src_prev <= src_s2;
    end
  end

  // Divide-by-16 prescalers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_pin2 <= 4'h0;
      div_xtal <= 4'h0;
    end else begin
      if (pin2_rise) begin
        div_pin2 <= div_pin2 + 4'h1;
      end
      if (src_rise[2]) begin
        div_xtal <= div_xtal + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      auxiliary_control_reg <= AUX_CTRL_RESET;
      interrupt_mask_reg <= INT_MASK_RESET;
    end else begin
      if (wr_aux) begin
        auxiliary_control_reg <= wdata_in;
      end
      if (wr_mask) begin
        interrupt_mask_reg <= wdata_in;
      end
    end
  end

  // change flags, set wins over read clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      change_flags <= INT_STATUS_RESET[3:0];
      change_summary <= INT_STATUS_RESET[CHANGE_BIT];
    end else begin
      change_flags <= (rd_change ? 4'h0 : change_flags) | change_evt;
      change_summary <= (rd_change ? 1'b0 : change_summary) | summary_evt;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
      ct_tick_out <= 1'b0;
      ct_square_mode_out <= 1'b0;
    end else begin
      rdata_out <= next_rdata;
      ct_tick_out <= next_tick;
      ct_square_mode_out <= ct_timer;
    end
  end

  assign irq_out_low = ~|(interrupt_status_reg & interrupt_mask_reg);

  a_flag_sets: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    change_evt[0] |=> change_flags[0])
    else $error("change flag 0 not set");
  a_read_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_change && change_evt == 4'h0) |=> change_flags == 4'h0)
    else $error("change flags not cleared by read");
  a_summary_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_change && !summary_evt) |=> !interrupt_status_reg[7])
    else $error("summary not cleared by read");
  a_live_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_change |=> rdata_out[3:0] == $past(sync2))
    else $error("live level wrong");
  a_irq_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (|(interrupt_status_reg & interrupt_mask_reg)) |-> !irq_out_low)
    else $error("irq not asserted");
  a_irq_masked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (interrupt_mask_reg == 8'h00) |-> irq_out_low)
    else $error("masked status drove irq");
  a_status_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_status |=> rdata_out == $past(interrupt_status_reg))
    else $error("status read masked");
  a_summary_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!interrupt_status_reg[7] && auxiliary_control_reg[3:0] == 4'h0) |=> !interrupt_status_reg[7])
    else $error("disabled change set summary");
  a_summary_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    summary_evt |=> interrupt_status_reg[7] ##1 1'b1)
    else $error("summary not set");
  a_timer_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ##1 ct_square_mode_out == $past(auxiliary_control_reg[6]))
    else $error("square mode flag wrong");
endmodule : input_change_interrupt_status
`default_nettype wire

// *** testbench/pin_model.sv ***
// Purpose: Far-side pins: general inputs and counter/timer source clocks
// Assumes: Bench asks for levels at falling edges; pins move on the rising edge
// Notes: Bits 3:0 general inputs, 4 chan A, 5 chan B, 6 crystal
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  input wire logic clk_in,
  input wire logic [7:0] lvl_in,
  output logic [7:0] pin_out
);
  // Copy on the other edge so the bench's writes never race it
  always @(posedge clk_in) pin_out <= lvl_in;
endmodule : pin_model
`default_nettype wire

// *** testbench/test_input_change_interrupt_status.sv ***
// Purpose: Self-checking bench for input change and interrupt status
// Assumes: Strobes raised and checked at falling edges
// Notes: Sources get 16/32/48/64 rising edges per mode run
`timescale 1ns/1ps
`default_nettype none
module test_input_change_interrupt_status;
  import ic_status_pkg::*;
  logic clk_in = 0, rst_n_in = 0, rd_in = 0, wr_in = 0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00, lvl = 8'h00, pins, rdata_out;
  logic [6:0] other = 7'h00;
  logic ct_tick_out, ct_square_mode_out, irq_out_low;
  logic [31:0] seed = 32'd55;
  int miscompares = 0, n_checks = 0, ticks = 0, t0 = 0;
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) if (ct_tick_out === 1'b1) ticks <= ticks + 1;
  pin_model u_pins (.clk_in(clk_in), .lvl_in(lvl), .pin_out(pins));
  input_change_interrupt_status u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .rd_in(rd_in), .wr_in(wr_in), .wdata_in(wdata_in),
    .rdata_out(rdata_out), .general_input_0(pins[0]), .general_input_1(pins[1]),
    .general_input_2(pins[2]), .general_input_3(pins[3]),
    .chan_a_tx_bit_clock(pins[4]), .chan_b_tx_bit_clock(pins[5]),
    .crystal_clock_in(pins[6]), .other_status_in(other), .ct_tick_out(ct_tick_out),
    .ct_square_mode_out(ct_square_mode_out), .irq_out_low(irq_out_low));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic int exp_ticks(input logic [2:0] code);
    case (code)
      3'h0, 3'h4: return 16;
      3'h1: return 32;
      3'h2: return 48;
      3'h5: return 1;
      3'h6: return 64;
      default: return 4;
    endcase
  endfunction : exp_ticks
  task automatic test_done;
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge clk_in);
  endtask : idle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_in = a;
    wdata_in = d;
    wr_in = 1'b1;
    @(negedge clk_in);
    wr_in = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(negedge clk_in);
    addr_in = a;
    rd_in = 1'b1;
    @(negedge clk_in);
    rd_in = 1'b0;
    chk(what, exp, rdata_out);
  endtask : rd
  initial begin
    #200000;
    miscompares++;
    test_done();
  end
  initial begin
    idle(12);
    rst_n_in = 1'b1;
    rd(ADDR_INT_STATUS, INT_STATUS_RESET, "status reset");
    chk("irq idle", 8'h01, {7'h0, irq_out_low});
    rd(4'h9, 8'h00, "unmapped");
    wr(ADDR_AUX_CTRL, 8'h0f);
    wr(ADDR_INT_MASK, 8'h80);
    for (int k = 0; k < 4; k++) begin
      lvl[k] = ~lvl[k];
      idle(6);
      chk("irq change", 8'h00, {7'h0, irq_out_low});
      rd(ADDR_INT_STATUS, 8'h80, "status change");
      rd(ADDR_INPUT_CHANGE, {4'h1 << k, lvl[3:0]}, "change reg");
      rd(ADDR_INPUT_CHANGE, {4'h0, lvl[3:0]}, "flags cleared");
      rd(ADDR_INT_STATUS, 8'h00, "status cleared");
      chk("irq cleared", 8'h01, {7'h0, irq_out_low});
    end
    wr(ADDR_AUX_CTRL, 8'h00);
    lvl[1] = ~lvl[1];
    idle(6);
    rd(ADDR_INT_STATUS, 8'h00, "status gated");
    rd(ADDR_INPUT_CHANGE, {4'h2, lvl[3:0]}, "flag gated");
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      other = seed[6:0];
      wr(ADDR_INT_MASK, seed[15:8]);
      rd(ADDR_INT_STATUS, {1'b0, seed[6:0]}, "status raw");
      chk("irq mask", {7'h0, ~|(seed[6:0] & seed[14:8])}, {7'h0, irq_out_low});
    end
    other = 7'h00;
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_AUX_CTRL, {1'b0, 3'(c), 4'h0});
      idle(4);
      chk("square mode", {7'h0, 1'(c >> 2)}, {7'h0, ct_square_mode_out});
      t0 = ticks;
      for (int j = 0; j < 128; j++) begin
        lvl[2] = (j < 32) & j[0];
        lvl[4] = (j < 64) & j[0];
        lvl[5] = (j < 96) & j[0];
        lvl[6] = j[0];
        idle(4);
      end
      idle(8);
      chk("ticks", 8'(exp_ticks(3'(c))), 8'(ticks - t0));
    end
    // Mid-run reset with a flag pending and pins not all low
    wr(ADDR_AUX_CTRL, 8'h0f);
    lvl[2] = ~lvl[2];
    idle(6);
    rd(ADDR_INT_STATUS, 8'h80, "status before reset");
    rst_n_in = 1'b0;
    idle(2);
    rst_n_in = 1'b1;
    rd(ADDR_INT_STATUS, INT_STATUS_RESET, "status mid reset");
    chk("irq mid reset", 8'h01, {7'h0, irq_out_low});
    rd(ADDR_INPUT_CHANGE, {4'h0, lvl[3:0]}, "flags mid reset");
    test_done();
  end
endmodule : test_input_change_interrupt_status
`default_nettype wire
